/* src/mode_control.sv */
// mode control register bank: control word, mode sequencing, soft reset
//
// The implementer's own choice: the Avalon-MM register port.
`timescale 1ns/100ps

module mode_control #(
  parameter int SRST_CYCLES = mode_ctl_pkg::SOFT_RESET_CYCLES
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // avalon-mm slave
  input wire mode_ctl_pkg::avl_req_s avl_req,
  output logic [mode_ctl_pkg::DATA_W-1:0] avl_readdata,
  output logic avl_waitrequest,
  // protocol engine status and control
  input wire mode_ctl_pkg::engine_stat_s eng_stat,
  output mode_ctl_pkg::ctl_cfg_s ctl_cfg
);
  import mode_ctl_pkg::*;

  localparam int CNT_W = $clog2(SRST_CYCLES + 1);
  localparam logic [CNT_W-1:0] SRST_LAST = CNT_W'(SRST_CYCLES - 1);

  // the counter logic needs at least one cycle of soft reset
  if (SRST_CYCLES < 1) begin : g_bad_srst
    $error("SRST_CYCLES must be at least 1");
  end

  logic ack_q;
  logic [DATA_W-1:0] rdata_q;
  logic [DATA_W-1:0] ctl_q;
  logic [DATA_W-1:0] ctl_d;
  logic [CNT_W-1:0] srst_cnt_q;
  op_mode_e mode_q;
  op_mode_e mode_d;
  logic sync_start_q;
  logic [1:0] warn_prev_q;
  logic [1:0] warn_irq_q;
  logic [1:0] warn_now;
  logic wr_fire;
  logic srst_busy;
  logic srst_done;
  logic inactive;
  logic disabled;
  logic enter_req;
  logic pn_state;
  logic [DATA_W-1:0] be_mask;
  logic [DATA_W-1:0] wr_mask;
  logic [DATA_W-1:0] status_word;
  logic [DATA_W-1:0] read_word;

  // one wait state on every access; the answer comes on the second cycle
  assign avl_waitrequest = (avl_req.read | avl_req.write) & ~ack_q;
  assign wr_fire = avl_req.write & ack_q & (avl_req.address == OFF_MODULE_CONTROL);

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= (avl_req.read | avl_req.write) & ~ack_q;
    end
  end

  // read data captured on the wait cycle, stands while waitrequest is low
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata_q <= '0;
    end else if (avl_req.read && !ack_q) begin
      rdata_q <= (avl_req.address == OFF_MODULE_CONTROL) ? read_word : '0;
    end
  end
  assign avl_readdata = rdata_q;

  // mode flags come straight from the mode flop
  assign inactive = (mode_q == MODE_INACTIVE);
  assign disabled = (mode_q == MODE_DISABLED);
  assign enter_req = ctl_q[BIT_HALT] & ctl_q[BIT_INACTIVE_MODE_ENABLE];
  assign pn_state = ctl_q[BIT_PRETEND_NET_ENABLE] & eng_stat.pn_active;
  assign srst_busy = ctl_q[BIT_SOFT_RESET];
  assign srst_done = srst_busy && (srst_cnt_q == SRST_LAST);

  // read-only bits: reserved positions stay zero
  always_comb begin
    status_word = '0;
    status_word[BIT_NOT_READY] = inactive | disabled;
    status_word[BIT_INACTIVE_STATE] = inactive;
    status_word[BIT_LOW_POWER] = disabled;
    status_word[BIT_PRETEND_NET_STATE] = pn_state;
  end
  assign read_word = (ctl_q & CTL_RW_MASK) | status_word;

  // byte lanes and the inactive-mode write lock
  always_comb begin
    be_mask = {{8{avl_req.byteenable[3]}}, {8{avl_req.byteenable[2]}},
               {8{avl_req.byteenable[1]}}, {8{avl_req.byteenable[0]}}};
    wr_mask = be_mask & (inactive ? CTL_RW_MASK : CTL_FREE_MASK);
  end

  // next control word; blocked bits just keep their value
  always_comb begin
    ctl_d = (ctl_q & ~wr_mask) | (avl_req.writedata & wr_mask);
    // a zero written to the soft reset bit has no effect
    ctl_d[BIT_SOFT_RESET] = ctl_q[BIT_SOFT_RESET] |
      (avl_req.writedata[BIT_SOFT_RESET] & wr_mask[BIT_SOFT_RESET]);
  end

  // control word; completion of soft reset restores all but kept bits
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      ctl_q <= CTL_RESET_VAL & CTL_RW_MASK;
    end else if (srst_done) begin
      ctl_q <= ((ctl_q & CTL_KEEP_MASK) |
                (CTL_RESET_VAL & ~CTL_KEEP_MASK)) & CTL_RW_MASK;
    end else if (wr_fire && !srst_busy) begin
      ctl_q <= ctl_d;
    end
  end

  // soft reset length; writes are ignored while it runs
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      srst_cnt_q <= '0;
    end else if (srst_busy && !srst_done) begin
      srst_cnt_q <= srst_cnt_q + CNT_W'(1);
    end else begin
      srst_cnt_q <= '0;
    end
  end

  // mode sequencing; entry from sync or run waits for an idle bus so no frame is cut
  always_comb begin
    mode_d = mode_q;
    unique case (mode_q)
      MODE_DISABLED: begin
        if (!ctl_q[BIT_MODULE_DISABLE]) begin
          mode_d = enter_req ? MODE_INACTIVE : MODE_SYNC;
        end
      end
      MODE_INACTIVE: begin
        if (ctl_q[BIT_MODULE_DISABLE]) begin
          mode_d = MODE_DISABLED;
        end else if (!enter_req) begin
          mode_d = MODE_SYNC;
        end
      end
      MODE_SYNC, MODE_RUN: begin
        if (ctl_q[BIT_MODULE_DISABLE]) begin
          mode_d = MODE_DISABLED;
        end else if (enter_req && eng_stat.bus_idle) begin
          mode_d = MODE_INACTIVE;
        end else if (mode_q == MODE_SYNC && eng_stat.bus_synced) begin
          mode_d = MODE_RUN;
        end
      end
    endcase
  end

  // the mode itself survives soft reset, keeping its flags
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      mode_q <= MODE_INACTIVE;
    end else begin
      mode_q <= mode_d;
    end
  end

  // one pulse when the engine must begin bus synchronisation
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      sync_start_q <= 1'b0;
    end else begin
      sync_start_q <= (mode_q != MODE_SYNC) && (mode_d == MODE_SYNC);
    end
  end

  // warning status change detection, one lane per direction
  assign warn_now = {eng_stat.tx_warning_state, eng_stat.rx_warning_state};
  for (genvar i = 0; i < 2; i++) begin : g_warn
    always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
        warn_prev_q[i] <= 1'b0;
        warn_irq_q[i] <= 1'b0;
      end else begin
        warn_prev_q[i] <= warn_now[i];
        warn_irq_q[i] <= ctl_q[BIT_WARNING_ENABLE] &
                         (warn_now[i] != warn_prev_q[i]);
      end
    end
  end

  // configuration handed to the frame engine
  always_comb begin
    ctl_cfg = '0;
    ctl_cfg.engine_enable = ~ctl_q[BIT_MODULE_DISABLE];
    ctl_cfg.engine_clock_enable = ~(inactive | disabled);
    ctl_cfg.soft_reset_active = srst_busy;
    ctl_cfg.sync_start = sync_start_q;
    ctl_cfg.rx_fifo_enable = ctl_q[BIT_RX_FIFO_ENABLE];
    ctl_cfg.rx_fifo_dma_enable = ctl_q[BIT_RX_FIFO_DMA_ENABLE];
    ctl_cfg.private_filter_queue_enable =
      ctl_q[BIT_PRIVATE_FILTER_QUEUE];
    ctl_cfg.self_receive_disable = ctl_q[BIT_SELF_RECEIVE_DISABLE];
    ctl_cfg.pretend_net_on = ctl_q[BIT_PRETEND_NET_ENABLE] &
                             ctl_q[BIT_PRETEND_NET_SELECT];
    ctl_cfg.local_priority_enable = ctl_q[BIT_LOCAL_PRIORITY];
    ctl_cfg.tx_abort_enable = ctl_q[BIT_TX_ABORT_ENABLE];
    ctl_cfg.flexible_rate_enable = ctl_q[BIT_FLEXIBLE_RATE];
    ctl_cfg.filter_element_format =
      ctl_q[FLD_FILTER_FORMAT_LSB +: 2];
    ctl_cfg.tx_warning_irq_flag = warn_irq_q[1];
    ctl_cfg.rx_warning_irq_flag = warn_irq_q[0];
    // memory: (n + 1) units of four words, at most 128 words
    ctl_cfg.message_memory_words = 8'(({3'h0,
      ctl_q[FLD_MEMORY_SIZE_LSB +: 5]} + 8'h01) * MEM_UNIT_WORDS);
    unique case (ctl_q[FLD_FILTER_FORMAT_LSB +: 2])
      FMT_ONE_FULL: ctl_cfg.filter_ids_per_element = 3'h1;
      FMT_TWO_IDS: ctl_cfg.filter_ids_per_element = 3'h2;
      FMT_FOUR_IDS: ctl_cfg.filter_ids_per_element = 3'h4;
      FMT_REJECT_ALL: begin
        ctl_cfg.filter_ids_per_element = 3'h0;
        ctl_cfg.filter_reject_all = 1'b1;
      end
    endcase
  end

  // helper: true only in the first cycle after reset release
  logic first_q;
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      first_q <= 1'b1;
    end else begin
      first_q <= 1'b0;
    end
  end

  property p_reset_value;
    @(posedge ref_clk) disable iff (!reset_n)
      first_q |-> read_word == CTL_RESET_VAL;
  endproperty
  a_reset_value: assert property (p_reset_value)
    else $error("control word not at reset pattern after reset");

  property p_write_lock;
    @(posedge ref_clk) disable iff (!reset_n)
      (wr_fire && !inactive && !srst_busy) |=>
        ((ctl_q & CTL_RW_MASK & ~CTL_FREE_MASK) ==
         $past(ctl_q & CTL_RW_MASK & ~CTL_FREE_MASK));
  endproperty
  a_write_lock: assert property (p_write_lock)
    else $error("locked bit changed outside inactive mode");

  property p_free_write;
    @(posedge ref_clk) disable iff (!reset_n)
      (wr_fire && !srst_busy && avl_req.byteenable[3]) |=>
        ctl_q[BIT_HALT] == $past(avl_req.writedata[BIT_HALT]);
  endproperty
  a_free_write: assert property (p_free_write)
    else $error("unblocked halt bit did not take the write");

  property p_srst_keep;
    @(posedge ref_clk) disable iff (!reset_n)
      srst_done |=> (ctl_q[BIT_MODULE_DISABLE] ==
        $past(ctl_q[BIT_MODULE_DISABLE])) &&
        ((ctl_q & ~CTL_KEEP_MASK) == (CTL_RESET_VAL & ~CTL_KEEP_MASK &
          CTL_RW_MASK));
  endproperty
  a_srst_keep: assert property (p_srst_keep)
    else $error("soft reset restored the wrong bits");

  property p_srst_len;
    @(posedge ref_clk) disable iff (!reset_n)
      (wr_fire && !srst_busy && wr_mask[BIT_SOFT_RESET] &&
       avl_req.writedata[BIT_SOFT_RESET]) |=>
        srst_busy [*4] ##1 !srst_busy;
  endproperty
  a_srst_len: assert property (p_srst_len)
    else $error("soft reset did not clear after four cycles");

  property p_disable;
    @(posedge ref_clk) disable iff (!reset_n)
      ctl_q[BIT_MODULE_DISABLE] |=> disabled && !ctl_cfg.engine_clock_enable;
  endproperty
  a_disable: assert property (p_disable)
    else $error("disable bit did not stop the controller");

  property p_inactive_entry;
    @(posedge ref_clk) disable iff (!reset_n)
      $rose(inactive) |-> $past(enter_req);
  endproperty
  a_inactive_entry: assert property (p_inactive_entry)
    else $error("inactive mode entered without halt and enable");

  property p_warn;
    @(posedge ref_clk) disable iff (!reset_n)
      (eng_stat.tx_warning_state != warn_prev_q[1]) |=>
        ctl_cfg.tx_warning_irq_flag == $past(ctl_q[BIT_WARNING_ENABLE]);
  endproperty
  a_warn: assert property (p_warn)
    else $error("tx warning flag disagrees with enable");

  property p_exit_sync;
    @(posedge ref_clk) disable iff (!reset_n)
      (inactive && !enter_req && !ctl_q[BIT_MODULE_DISABLE]) |=>
        ctl_cfg.sync_start;
  endproperty
  a_exit_sync: assert property (p_exit_sync)
    else $error("no sync start after leaving inactive mode");

  // writes that land during a soft reset are ignored; all but the kept disable bit would be lost at its end anyway
  property p_srst_hold;
    @(posedge ref_clk) disable iff (!reset_n)
      (srst_busy && !srst_done) |=> ctl_q == $past(ctl_q);
  endproperty
  a_srst_hold: assert property (p_srst_hold)
    else $error("control word changed while soft reset ran");

  property p_srst_zero;
    @(posedge ref_clk) disable iff (!reset_n)
      (wr_fire && !srst_busy && !avl_req.writedata[BIT_SOFT_RESET]) |=>
        !srst_busy;
  endproperty
  a_srst_zero: assert property (p_srst_zero)
    else $error("writing zero started a soft reset");

  property p_sync_run;
    @(posedge ref_clk) disable iff (!reset_n)
      (mode_q == MODE_SYNC && eng_stat.bus_synced && !enter_req &&
       !ctl_q[BIT_MODULE_DISABLE]) |=> mode_q == MODE_RUN;
  endproperty
  a_sync_run: assert property (p_sync_run)
    else $error("synchronised engine did not start running");

  property p_stay_inactive;
    @(posedge ref_clk) disable iff (!reset_n)
      (inactive && enter_req && !ctl_q[BIT_MODULE_DISABLE]) |=> inactive;
  endproperty
  a_stay_inactive: assert property (p_stay_inactive)
    else $error("inactive mode left while halt was requested");

  property p_warn_rx;
    @(posedge ref_clk) disable iff (!reset_n)
      (eng_stat.rx_warning_state != warn_prev_q[0]) |=>
        ctl_cfg.rx_warning_irq_flag == $past(ctl_q[BIT_WARNING_ENABLE]);
  endproperty
  a_warn_rx: assert property (p_warn_rx)
    else $error("rx warning flag disagrees with enable");

  c_enter_inactive: cover property (@(posedge ref_clk) disable iff
    (!reset_n) $rose(inactive));
  c_soft_reset: cover property (@(posedge ref_clk) disable iff
    (!reset_n) srst_done);
  c_run: cover property (@(posedge ref_clk) disable iff
    (!reset_n) $rose(mode_q == MODE_RUN));
  c_disabled: cover property (@(posedge ref_clk) disable iff
    (!reset_n) $rose(disabled));
  c_sync_start: cover property (@(posedge ref_clk) disable iff
    (!reset_n) ctl_cfg.sync_start);
endmodule : mode_control

/* src/mode_ctl_pkg.sv */
// package: offsets, field layout, reset values and types of the mode control
package mode_ctl_pkg;
  // bus geometry
  localparam int ADDR_W = 4;
  localparam int DATA_W = 32;
  localparam logic [ADDR_W-1:0] OFF_MODULE_CONTROL = 4'h0;

  // field positions of module_control
  localparam int BIT_MODULE_DISABLE = 31;
  localparam int BIT_INACTIVE_MODE_ENABLE = 30;
  localparam int BIT_RX_FIFO_ENABLE = 29;
  localparam int BIT_HALT = 28;
  localparam int BIT_NOT_READY = 27;
  localparam int BIT_SOFT_RESET = 25;
  localparam int BIT_INACTIVE_STATE = 24;
  localparam int BIT_WARNING_ENABLE = 21;
  localparam int BIT_LOW_POWER = 20;
  localparam int BIT_PRETEND_NET_ENABLE = 19;
  localparam int BIT_PRETEND_NET_STATE = 18;
  localparam int BIT_SELF_RECEIVE_DISABLE = 17;
  localparam int BIT_PRIVATE_FILTER_QUEUE = 16;
  localparam int BIT_RX_FIFO_DMA_ENABLE = 15;
  localparam int BIT_PRETEND_NET_SELECT = 14;
  localparam int BIT_LOCAL_PRIORITY = 13;
  localparam int BIT_TX_ABORT_ENABLE = 12;
  localparam int BIT_FLEXIBLE_RATE = 11;
  localparam int FLD_FILTER_FORMAT_LSB = 8;
  localparam int FLD_MEMORY_SIZE_LSB = 0;

  // masks and reset value
  localparam logic [DATA_W-1:0] CTL_RESET_VAL = 32'h5900_000F;
  localparam logic [DATA_W-1:0] CTL_RW_MASK = 32'hF22B_FB1F;
  localparam logic [DATA_W-1:0] CTL_FREE_MASK = 32'h5208_0000;
  localparam logic [DATA_W-1:0] CTL_KEEP_MASK = 32'h8910_0000;

  // filter formats and memory sizing
  localparam logic [1:0] FMT_ONE_FULL = 2'h0;
  localparam logic [1:0] FMT_TWO_IDS = 2'h1;
  localparam logic [1:0] FMT_FOUR_IDS = 2'h2;
  localparam logic [1:0] FMT_REJECT_ALL = 2'h3;
  localparam logic [7:0] MEM_UNIT_WORDS = 8'h04;

  // soft reset duration in ref_clk cycles
  localparam int SOFT_RESET_CYCLES = 4;

  typedef enum logic [1:0] {
    MODE_DISABLED, MODE_INACTIVE, MODE_SYNC, MODE_RUN
  } op_mode_e;

  typedef struct packed {
    logic read;
    logic write;
    logic [ADDR_W-1:0] address;
    logic [3:0] byteenable;
    logic [DATA_W-1:0] writedata;
  } avl_req_s;

  typedef struct packed {
    logic bus_idle;
    logic bus_synced;
    logic pn_active;
    logic tx_warning_state;
    logic rx_warning_state;
  } engine_stat_s;

  typedef struct packed {
    logic engine_enable;
    logic engine_clock_enable;
    logic soft_reset_active;
    logic sync_start;
    logic rx_fifo_enable;
    logic rx_fifo_dma_enable;
    logic private_filter_queue_enable;
    logic self_receive_disable;
    logic pretend_net_on;
    logic local_priority_enable;
    logic tx_abort_enable;
    logic flexible_rate_enable;
    logic [1:0] filter_element_format;
    logic filter_reject_all;
    logic [2:0] filter_ids_per_element;
    logic [7:0] message_memory_words;
    logic tx_warning_irq_flag;
    logic rx_warning_irq_flag;
  } ctl_cfg_s;
endpackage : mode_ctl_pkg

/* dv/host_model.sv */
// host software model: avalon-mm master doing word accesses
`timescale 1ns/100ps
module host_model (
  // clock
  input wire logic ref_clk,
  // avalon-mm master side
  output mode_ctl_pkg::avl_req_s avl_req,
  input wire logic [mode_ctl_pkg::DATA_W-1:0] avl_readdata,
  input wire logic avl_waitrequest
);
  import mode_ctl_pkg::*;
  // reserved positions, always written with their reset value of zero
  localparam logic [DATA_W-1:0] RSV_MASK = 32'h04C0_04E0;

  initial avl_req = '0;

  // one access; request held until waitrequest is sampled low
  task automatic access(input logic wr, input logic [ADDR_W-1:0] adr,
    input logic [DATA_W-1:0] wd, output logic [DATA_W-1:0] rd);
    avl_req <= '{read: ~wr, write: wr, address: adr,
      byteenable: 4'hF, writedata: wd & ~RSV_MASK};
    @(posedge ref_clk);
    while (avl_waitrequest !== 1'b0) begin
      @(posedge ref_clk);
    end
    rd = avl_readdata;
    // idle cycle after release, so two requests never share a step
    avl_req <= '0;
    @(posedge ref_clk);
  endtask : access
endmodule : host_model

/* dv/mode_control_tb_top.sv */
// self-checking testbench for the mode control register bank
`timescale 1ns/100ps
module mode_control_tb_top;
  import mode_ctl_pkg::*;
  logic ref_clk;
  logic reset_n;
  avl_req_s avl_req;
  logic [DATA_W-1:0] avl_readdata;
  logic avl_waitrequest;
  engine_stat_s eng_stat;
  ctl_cfg_s ctl_cfg;
  int failures;
  int checks;
  int cycles;

  mode_control #(.SRST_CYCLES(SOFT_RESET_CYCLES)) dut (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .avl_req(avl_req),
    .avl_readdata(avl_readdata),
    .avl_waitrequest(avl_waitrequest),
    .eng_stat(eng_stat),
    .ctl_cfg(ctl_cfg)
  );

  host_model host (
    .ref_clk(ref_clk),
    .avl_req(avl_req),
    .avl_readdata(avl_readdata),
    .avl_waitrequest(avl_waitrequest)
  );

  // 50 mhz clock
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  task automatic finish_test();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : finish_test

  // hang guard, far above the hundred-odd cycles needed
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      failures++;
      finish_test();
    end
  end

  task automatic check_word(input string what, input logic [31:0] exp,
    input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : check_word

  task automatic check_flag(input string what, input logic exp,
    input logic got);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %s expected %b seen %b", what, exp, got);
    end
  endtask : check_flag

  task automatic expect_reg(input string what, input logic [31:0] exp);
    logic [31:0] d;
    host.access(1'b0, OFF_MODULE_CONTROL, 32'h0000_0000, d);
    check_word(what, exp, d);
  endtask : expect_reg

  // extra edge lets derived config outputs settle
  task automatic put_reg(input logic [31:0] wd);
    logic [31:0] d;
    host.access(1'b1, OFF_MODULE_CONTROL, wd, d);
    @(posedge ref_clk);
  endtask : put_reg

  // toggle one warning state, then watch for its pulse
  task automatic warn_pulse(input logic tx, output logic seen);
    seen = 1'b0;
    if (tx)
      eng_stat.tx_warning_state <= ~eng_stat.tx_warning_state;
    else
      eng_stat.rx_warning_state <= ~eng_stat.rx_warning_state;
    repeat (4) begin
      @(posedge ref_clk);
      if (tx)
        seen = seen | ctl_cfg.tx_warning_irq_flag;
      else
        seen = seen | ctl_cfg.rx_warning_irq_flag;
    end
  endtask : warn_pulse

  task automatic wait_srst();
    int n;
    n = 0;
    while (ctl_cfg.soft_reset_active !== 1'b0 && n < 40) begin
      n++;
      @(posedge ref_clk);
    end
  endtask : wait_srst

  task automatic t_reset();
    logic [31:0] d;
    expect_reg("reset word", CTL_RESET_VAL);
    check_flag("clock enable", 1'b0, ctl_cfg.engine_clock_enable);
    check_word("memory words", 32'h0000_0040,
      {24'h00_0000, ctl_cfg.message_memory_words});
    host.access(1'b1, 4'h4, 32'hFFFF_FFFF, d);
    host.access(1'b0, 4'h4, 32'h0000_0000, d);
    check_word("unmapped read", 32'h0000_0000, d);
    expect_reg("after unmapped write", CTL_RESET_VAL);
    $display("reset test done");
  endtask : t_reset

  // inactive mode: every field writable, formats decoded
  task automatic t_config();
    logic [2:0] ids [4];
    logic seen;
    ids = '{3'h1, 3'h2, 3'h4, 3'h0};
    for (int f = 0; f < 4; f++) begin
      put_reg(32'h7023_F81F | (32'(f) << 8));
      check_word("ids", {29'h0, ids[f]},
        {29'h0, ctl_cfg.filter_ids_per_element});
      check_flag("reject all", f == 3, ctl_cfg.filter_reject_all);
      check_word("format", 32'(f),
        {30'h0, ctl_cfg.filter_element_format});
    end
    put_reg(32'h7023_F91F);
    expect_reg("inactive config", 32'h7923_F91F);
    check_word("enables", 32'h0000_007F, {25'h0,
      ctl_cfg.rx_fifo_enable, ctl_cfg.rx_fifo_dma_enable,
      ctl_cfg.private_filter_queue_enable, ctl_cfg.self_receive_disable,
      ctl_cfg.local_priority_enable, ctl_cfg.tx_abort_enable,
      ctl_cfg.flexible_rate_enable});
    check_word("memory words max", 32'h0000_0080,
      {24'h00_0000, ctl_cfg.message_memory_words});
    warn_pulse(1'b1, seen);
    check_flag("tx warning pulse", 1'b1, seen);
    warn_pulse(1'b0, seen);
    check_flag("rx warning pulse", 1'b1, seen);
    $display("config test done");
  endtask : t_config

  // leave inactive, then write while running
  task automatic t_run();
    logic [31:0] d;
    logic seen;
    eng_stat.bus_synced <= 1'b1;
    host.access(1'b1, OFF_MODULE_CONTROL, 32'h6023_F91F, d);
    // the start pulse stands one cycle, so look at every edge
    seen = 1'b0;
    repeat (3) begin
      @(posedge ref_clk);
      seen = seen | ctl_cfg.sync_start;
    end
    check_flag("sync start", 1'b1, seen);
    expect_reg("running word", 32'h6023_F91F);
    check_flag("clock enable run", 1'b1, ctl_cfg.engine_clock_enable);
    eng_stat.pn_active <= 1'b1;
    put_reg(32'h0008_0000);
    expect_reg("blocked write", 32'h202F_F91F);
    check_flag("pretend net on", 1'b1, ctl_cfg.pretend_net_on);
    $display("run test done");
  endtask : t_run

  // soft reset while running keeps the mode flags
  task automatic t_soft();
    logic seen;
    put_reg(32'h5208_0000);
    check_flag("soft reset busy", 1'b1, ctl_cfg.soft_reset_active);
    wait_srst();
    expect_reg("after soft reset", 32'h5000_000F);
    warn_pulse(1'b0, seen);
    check_flag("masked warning", 1'b0, seen);
    eng_stat.bus_idle <= 1'b1;
    repeat (3) @(posedge ref_clk);
    expect_reg("halted word", CTL_RESET_VAL);
    $display("soft reset test done");
  endtask : t_soft

  // disable is left only by a hard reset
  task automatic t_disable();
    put_reg(32'hD000_000F);
    expect_reg("disabled word", 32'hD810_000F);
    check_flag("engine enable", 1'b0, ctl_cfg.engine_enable);
    put_reg(32'h0200_0000);
    wait_srst();
    expect_reg("disabled soft reset", 32'hD810_000F);
    reset_n <= 1'b0;
    repeat (4) @(posedge ref_clk);
    reset_n <= 1'b1;
    @(posedge ref_clk);
    expect_reg("second reset", CTL_RESET_VAL);
    $display("disable test done");
  endtask : t_disable

  // main sequence
  initial begin
    reset_n = 1'b0;
    eng_stat = '0;
    repeat (4) @(posedge ref_clk);
    reset_n <= 1'b1;
    @(posedge ref_clk);
    t_reset();
    t_config();
    t_run();
    t_soft();
    t_disable();
    finish_test();
  end
endmodule : mode_control_tb_top
